// *** conv_model.sv ***
`timescale 1ns/10ps
// converter model: one reading per request, prompt or slow
module conv_model
  import sweep_buf_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_ni, // reset, active low
  input wire logic go_i, // request one reading
  input wire logic [2:0] dly_i, // answer delay
  input wire reading_type val_i, // reading to send
  output logic valid_o, // one-cycle strobe
  output reading_type rdg_o // reading
);
  logic [3:0] cnt;
  // data is scrambled off the strobe so nothing relies on a stale value
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      {valid_o, rdg_o, cnt} <= '0;
    end else begin
      valid_o <= cnt == 4'h1;
      rdg_o <= (cnt == 4'h1) ? val_i : ~rdg_o;
      if (go_i) cnt <= {1'b0, dly_i} + 4'h1;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
endmodule : conv_model

// *** sweep_buf_pkg.sv ***
// constants and types of the sweep reading buffer controller
//
// Functional notes
// - two 450-word buffers: acquisition, secondary
// - triple per word; cap-only 1350 at fastest
// - secondary buffer filled only by transfer
// - last-reading register holds every new reading
// - locations 1..450, stored ascending from 1
// - one-shot: one reading per trigger
// - count from bias settings or count parameter
// - bias returns to default after sweep
// - one-shot trigger after sweep clears buffer
// - sweep trigger takes all n readings
// - after sweep only last-reading register updates
// - sweep start trigger clears acquisition buffer
// - bias/transfer commands and setting changes abort and clear
// - empty buffer reads as invalid reading
// - fast rates invalid until sweep completes
// - browse entry selects buffer, location 1
// - step up/down saturating at ends
// - jump to first or last valid location
// - quit ends browsing, indicator off
// - browsing keeps storing except fast rates
// - transfer copies valid entries and header
// - transfer clears acquisition, aborts; empty clears
// - step lasts step time plus measurement
package sweep_buf_pkg;
  localparam int WORDS = 450;
  localparam logic [10:0] CAP_FULL = 11'h1C2;
  localparam logic [10:0] CAP_FAST = 11'h546;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BIAS_FL = 8'h04;
  localparam logic [7:0] A_BIAS_SD = 8'h08;
  localparam logic [7:0] A_COUNT = 8'h0C;
  localparam logic [7:0] A_TIME_SS = 8'h10;
  localparam logic [7:0] A_TIME_STOP = 8'h14;
  localparam logic [7:0] A_CMD = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_LAST_CG = 8'h20;
  localparam logic [7:0] A_LAST_V = 8'h24;
  localparam logic [7:0] A_VIEW_CG = 8'h28;
  localparam logic [7:0] A_VIEW_V = 8'h2C;
  // control fields
  localparam int CTRL_SWEEP = 0;
  localparam int CTRL_RATE = 1;
  localparam int CTRL_WAVE = 4;
  localparam int CTRL_ZERO = 7;
  localparam logic [2:0] RATE_75 = 3'h3;
  localparam logic [2:0] RATE_1000 = 3'h4;
  localparam logic [2:0] WAVE_DC = 3'h0;
  localparam logic [2:0] WAVE_DUAL = 3'h2;
  localparam logic [2:0] WAVE_PULSE = 3'h3;
  localparam logic [2:0] WAVE_EXT = 3'h4;
  // command bits, each a one-shot action
  localparam int CMD_BIAS = 4;
  localparam int CMD_ENTER = 5;
  localparam int CMD_SEL = 6;
  localparam int CMD_UP = 7;
  localparam int CMD_DOWN = 8;
  localparam int CMD_FIRST = 9;
  localparam int CMD_LAST = 10;
  localparam int CMD_QUIT = 11;
  localparam int CMD_XFER = 12;
  localparam int CMD_INDEX = 13;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [10:0] COUNT_RST = 11'h001;
  localparam logic [15:0] INVALID_WORD = 16'hFFFF;
  typedef struct packed {
    logic [15:0] cap;
    logic [15:0] cond;
    logic [15:0] bias;
  } reading_type;
  typedef struct packed {
    logic zero_en;
    logic cap_only;
  } header_type;
  typedef enum {S_IDLE, S_START, S_STEP, S_MEAS, S_STOP, S_HOLD}
    sweep_state_type;
endpackage : sweep_buf_pkg

// *** sweep_buf_sva.sv ***
`timescale 1ns/10ps
// port assertions for the sweep reading buffer controller
module sweep_buf_sva
  import sweep_buf_pkg::*;
(
  input wire logic core_clk_i, // clock
  input wire logic resetn_i, // reset
  input wire logic psel_i, // select
  input wire logic penable_i, // enable
  input wire logic pwrite_i, // direction
  input wire logic [7:0] paddr_i, // address
  input wire logic [31:0] pwdata_i, // write data
  input wire logic pready_o, // ready
  input wire logic pslverr_o, // error
  input wire logic sweep_active_o, // sweep running
  input wire logic buffer_display_o, // browsing
  input wire reading_type disp_o, // display
  input wire logic disp_invalid_o // invalid shown
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic cmd_wr;
  // a command write completes at this edge
  assign cmd_wr = pready_o && pwrite_i && paddr_i == A_CMD;
  property p_ready_next; psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("late ready");
  property p_ready_one; pready_o |=> !pready_o; endproperty
  a_ready_one: assert property (p_ready_one) else $error("long ready");
  property p_unmapped;
    pready_o && (paddr_i > A_VIEW_V || paddr_i[1:0] != 2'h0) |-> pslverr_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_invalid; disp_invalid_o |-> disp_o == {3{INVALID_WORD}};
  endproperty
  a_invalid: assert property (p_invalid) else $error("bad invalid");
  property p_enter;
    $rose(buffer_display_o) |-> $past(cmd_wr && pwdata_i[CMD_ENTER]);
  endproperty
  a_enter: assert property (p_enter) else $error("stray browse");
  property p_quit;
    cmd_wr && pwdata_i[CMD_QUIT] && !pwdata_i[CMD_ENTER] |=> !buffer_display_o;
  endproperty
  a_quit: assert property (p_quit) else $error("quit ignored");
  property p_live; !buffer_display_o |=> !disp_invalid_o; endproperty
  a_live: assert property (p_live) else $error("stale invalid");
  property p_xfer; cmd_wr && pwdata_i[CMD_XFER] |=> ##[0:2] !sweep_active_o;
  endproperty
  a_xfer: assert property (p_xfer) else $error("no abort");
  property p_cfg;
    pready_o && pwrite_i && paddr_i == A_CTRL |=> ##[0:2] !sweep_active_o;
  endproperty
  a_cfg: assert property (p_cfg) else $error("no abort");
endmodule : sweep_buf_sva

// *** sweep_reading_buffer_ctrl.sv ***
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
// sweep reading buffer controller: sequencing, storage, browse, transfer
module sweep_reading_buffer_ctrl #(
  parameter int TICK_CYCLES =
    sweep_buf_pkg::MS_NS / sweep_buf_pkg::CLK_PERIOD_NS
) (
  input wire logic core_clk_i, // 20 MHz clock
  input wire logic resetn_i, // async reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error, unmapped
  input wire logic trigger_i, // trigger pin, async
  input wire logic rdg_valid_i, // converter reading strobe
  input wire sweep_buf_pkg::reading_type rdg_i, // converter reading
  output logic [15:0] bias_o, // bias level request
  output logic sweep_active_o, // sweep in progress
  output logic buffer_display_o, // buffer browse indicator
  output sweep_buf_pkg::reading_type disp_o, // display data
  output logic disp_invalid_o // display shows invalid
);
  import sweep_buf_pkg::*;

  // decode of mapped offsets, used by write and error logic
  function automatic logic is_cfg(input logic [7:0] a);
    is_cfg = (a == A_CTRL) || (a == A_BIAS_FL) || (a == A_BIAS_SD) ||
             (a == A_COUNT) || (a == A_TIME_SS) || (a == A_TIME_STOP);
  endfunction : is_cfg

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_cfg(a) || (a == A_CMD) || (a == A_STATUS) ||
                (a == A_LAST_CG) || (a == A_LAST_V) ||
                (a == A_VIEW_CG) || (a == A_VIEW_V);
  endfunction : is_mapped

  // position of the newest entry behind a write pointer
  function automatic logic [10:0] last_pos(input logic [8:0] w,
                                           input logic [1:0] l,
                                           input logic co);
    last_pos = {w, l};
    if (l != 2'h0) begin
      last_pos = {w, l - 2'h1};
    end else if (w != 9'h000) begin
      last_pos = {w - 9'h001, co ? 2'h2 : 2'h0};
    end
  endfunction : last_pos

  logic [7:0] ctrl;
  logic signed [15:0] bias_first;
  logic signed [15:0] bias_last;
  logic signed [15:0] bias_step;
  logic [15:0] bias_dflt;
  logic [10:0] count_prm;
  logic [15:0] t_start;
  logic [15:0] t_step;
  logic [15:0] t_stop;
  logic wr_fire;
  logic cfg_wr;
  logic [13:0] cmd;
  logic [2:0] trg_sync;
  logic trg_rise;
  sweep_state_type state;
  logic [15:0] tmr_ms;
  logic [23:0] pre;
  logic tmr_zero;
  logic signed [15:0] bias_cur;
  logic phase;
  logic fin;
  logic [10:0] steps;
  logic [10:0] count_a;
  logic [10:0] count_b;
  logic [8:0] wa_word;
  logic [1:0] wa_lane;
  logic [8:0] wb_word;
  logic [1:0] wb_lane;
  header_type hdr_a;
  header_type hdr_b;
  logic a_complete;
  logic xfer_busy;
  logic [8:0] xfer_idx;
  logic [47:0] buf_a [WORDS];
  logic [47:0] buf_b [WORDS];
  logic bsel;
  logic [10:0] bptr;
  logic [8:0] bword;
  logic [1:0] blane;
  logic show_location_index;
  reading_type last_rdg;
  logic [47:0] view_word;
  logic view_co;
  logic view_invalid;
  logic sweep_mode;
  logic [2:0] rate;
  logic [2:0] wave;
  logic fast;
  logic cap_only;
  logic [10:0] cap;
  logic [10:0] cnt_lim;
  logic [10:0] steps_next;
  logic abort;
  logic xfer_go;
  logic start_go;
  logic store_en;
  logic done_now;
  logic stair_end;
  logic signed [15:0] tgt;
  logic signed [16:0] stp;
  logic signed [16:0] sum;
  logic over;
  logic sweep_end;
  logic [8:0] a_last_word;
  logic sel_co;
  logic [10:0] sel_count;
  logic [10:0] sel_last;

  // settings decode
  assign sweep_mode = ctrl[CTRL_SWEEP];
  assign rate = ctrl[CTRL_RATE +: 3];
  assign wave = ctrl[CTRL_WAVE +: 3];
  assign fast = (rate >= RATE_75);
  assign cap_only = (rate == RATE_1000);
  assign cap = cap_only ? CAP_FAST : CAP_FULL;

  // write effects land on the edge where the master sees pready
  assign wr_fire = psel_i && penable_i && pready_o && pwrite_i;
  assign cfg_wr = wr_fire && is_cfg(paddr_i);
  assign cmd = (wr_fire && paddr_i == A_CMD) ? pwdata_i[13:0] : 14'h0000;

  // abort sources: commands or setting writes
  assign xfer_go = cmd[CMD_XFER] && !xfer_busy;
  assign abort = (|cmd[CMD_BIAS:0]) || cfg_wr || xfer_go;
  // trigger from idle clears and restarts
  assign start_go = trg_rise && !abort && !xfer_busy &&
                    (state == S_IDLE);
  // fast rates hold storage while browsing
  assign store_en = (state == S_MEAS) && rdg_valid_i && !abort &&
                    !(buffer_display_o && fast);

  // reading count from bias walk or count
  assign cnt_lim = (count_prm > cap) ? cap : count_prm;
  assign steps_next = steps + 11'h001;
  assign tgt = phase ? bias_first : bias_last;
  assign stair_end = (bias_step == 16'sh0000) ||
                     ((bias_cur == tgt) && (wave != WAVE_DUAL || phase));
  assign done_now = (steps_next >= cap) ||
    ((wave == WAVE_DC || wave == WAVE_EXT) ? (steps_next >= cnt_lim)
                                          : stair_end);
  assign stp = phase ? -17'(bias_step) : 17'(bias_step);
  assign sum = 17'(bias_cur) + stp;
  assign over = stp[16] ? (sum < 17'(tgt)) : (sum > 17'(tgt));
  assign tmr_zero = (tmr_ms == 16'h0000);
  assign sweep_end = (state == S_STOP) && tmr_zero && fin && !abort;
  assign a_last_word = (wa_lane == 2'h0) ? wa_word - 9'h001 : wa_word;

  // browse target view of the selected buffer
  assign sel_co = bsel ? hdr_b.cap_only
                       : ((count_a == 11'h000) ? cap_only : hdr_a.cap_only);
  assign sel_count = bsel ? count_b : count_a;
  assign sel_last = bsel ? last_pos(wb_word, wb_lane, sel_co)
                         : last_pos(wa_word, wa_lane, sel_co);

  // configuration registers
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= CTRL_RST;
      bias_first <= WORD_RST;
      bias_last <= WORD_RST;
      bias_step <= WORD_RST;
      bias_dflt <= WORD_RST;
      count_prm <= COUNT_RST;
      t_start <= WORD_RST;
      t_step <= WORD_RST;
      t_stop <= WORD_RST;
    end else if (cfg_wr) begin
      case (paddr_i)
        A_CTRL: ctrl <= pwdata_i[7:0];
        A_BIAS_FL: begin
          bias_first <= pwdata_i[15:0];
          bias_last <= pwdata_i[31:16];
        end
        A_BIAS_SD: begin
          bias_step <= pwdata_i[15:0];
          bias_dflt <= pwdata_i[31:16];
        end
        A_COUNT: count_prm <= pwdata_i[10:0];
        A_TIME_SS: begin
          t_start <= pwdata_i[15:0];
          t_step <= pwdata_i[31:16];
        end
        A_TIME_STOP: t_stop <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // apb answer: one wait state, so ready and data come from flops
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o &&
                   !is_mapped(paddr_i);
      case (paddr_i)
        A_CTRL: prdata_o <= {24'h000000, ctrl};
        A_BIAS_FL: prdata_o <= {bias_last, bias_first};
        A_BIAS_SD: prdata_o <= {bias_dflt, bias_step};
        A_COUNT: prdata_o <= {21'h000000, count_prm};
        A_TIME_SS: prdata_o <= {t_step, t_start};
        A_TIME_STOP: prdata_o <= {16'h0000, t_stop};
        A_STATUS: prdata_o <= {6'h00, a_complete, xfer_busy,
                               buffer_display_o, sweep_active_o,
                               count_b, count_a};
        A_LAST_CG: prdata_o <= {last_rdg.cap, last_rdg.cond};
        A_LAST_V: prdata_o <= {16'h0000, last_rdg.bias};
        A_VIEW_CG: prdata_o <= {disp_o.cap, disp_o.cond};
        A_VIEW_V: prdata_o <= {15'h0000, disp_invalid_o, disp_o.bias};
        default: prdata_o <= 32'h00000000;
      endcase
    end
  end

  // trigger pin synchroniser; only stage two onward is examined
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trg_sync <= 3'h0;
    end else begin
      trg_sync <= {trg_sync[1:0], trigger_i};
    end
  end
  assign trg_rise = trg_sync[1] && !trg_sync[2];

  // sweep sequencer with millisecond timer; loads restart the
  // prescaler so a programmed time is never cut short
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= S_IDLE;
      tmr_ms <= 16'h0000;
      pre <= 24'h000000;
      bias_cur <= 16'sh0000;
      phase <= 1'b0;
      fin <= 1'b0;
      steps <= 11'h000;
    end else begin
      if (pre >= 24'(TICK_CYCLES - 1)) begin
        pre <= 24'h000000;
        if (!tmr_zero) begin
          tmr_ms <= tmr_ms - 16'h0001;
        end
      end else begin
        pre <= pre + 24'h000001;
      end
      if (abort) begin
        state <= S_IDLE;
      end else begin
        case (state)
          S_IDLE: begin
            if (start_go) begin
              state <= S_START;
              tmr_ms <= t_start;
              pre <= 24'h000000;
              bias_cur <= bias_first;
              phase <= 1'b0;
              fin <= 1'b0;
              steps <= 11'h000;
            end
          end
          S_START: begin
            if (tmr_zero) begin
              state <= S_STEP;
              tmr_ms <= t_step;
              pre <= 24'h000000;
            end
          end
          S_STEP: begin
            if (tmr_zero) begin
              state <= S_MEAS;
            end
          end
          S_MEAS: begin
            if (store_en) begin
              steps <= steps_next;
              fin <= done_now;
              if (bias_cur == tgt && !phase) begin
                phase <= 1'b1;
                bias_cur <= bias_cur - bias_step;
              end else begin
                bias_cur <= over ? tgt : sum[15:0];
              end
              // sweep runs all steps on one trigger
              if (wave == WAVE_PULSE || done_now) begin
                state <= S_STOP;
                tmr_ms <= t_stop;
                pre <= 24'h000000;
              end else if (sweep_mode) begin
                state <= S_STEP;
                tmr_ms <= t_step;
                pre <= 24'h000000;
              end else begin
                state <= S_HOLD;
              end
            end
          end
          S_STOP: begin
            if (tmr_zero) begin
              if (fin) begin
                state <= S_IDLE;
              end else if (sweep_mode) begin
                state <= S_STEP;
                tmr_ms <= t_step;
                pre <= 24'h000000;
              end else begin
                state <= S_HOLD;
              end
            end
          end
          S_HOLD: begin
            if (trg_rise) begin
              state <= S_STEP;
              tmr_ms <= t_step;
              pre <= 24'h000000;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // bias request and activity flag
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bias_o <= WORD_RST;
      sweep_active_o <= 1'b0;
    end else begin
      sweep_active_o <= (state != S_IDLE);
      // default bias outside the stepping phases
      if (state inside {S_START, S_STEP, S_MEAS, S_HOLD} &&
          wave != WAVE_EXT) begin
        bias_o <= (wave == WAVE_DC) ? bias_first : bias_cur;
      end else begin
        bias_o <= bias_dflt;
      end
    end
  end

  // buffer bookkeeping: counts, pointers, headers, transfer
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_a <= 11'h000;
      wa_word <= 9'h000;
      wa_lane <= 2'h0;
      hdr_a <= 2'b00;
      count_b <= 11'h000;
      wb_word <= 9'h000;
      wb_lane <= 2'h0;
      hdr_b <= 2'b00;
      a_complete <= 1'b0;
      xfer_busy <= 1'b0;
      xfer_idx <= 9'h000;
    end else if (xfer_busy) begin
      if (xfer_idx == a_last_word) begin
        // after the copy buffer A is emptied
        count_b <= count_a;
        wb_word <= wa_word;
        wb_lane <= wa_lane;
        hdr_b <= hdr_a;
        count_a <= 11'h000;
        wa_word <= 9'h000;
        wa_lane <= 2'h0;
        a_complete <= 1'b0;
        xfer_busy <= 1'b0;
      end else begin
        xfer_idx <= xfer_idx + 9'h001;
      end
    end else if (xfer_go) begin
      // empty source still clears buffer B
      if (count_a == 11'h000) begin
        count_b <= 11'h000;
        wb_word <= 9'h000;
        wb_lane <= 2'h0;
        a_complete <= 1'b0;
      end else begin
        xfer_busy <= 1'b1;
        xfer_idx <= 9'h000;
      end
    end else if (abort || start_go) begin
      // abort or new sweep empties buffer A
      count_a <= 11'h000;
      wa_word <= 9'h000;
      wa_lane <= 2'h0;
      a_complete <= 1'b0;
    end else if (store_en) begin
      if (count_a == 11'h000) begin
        hdr_a <= {ctrl[CTRL_ZERO], cap_only};
      end
      count_a <= count_a + 11'h001;
      if (cap_only && wa_lane != 2'h2) begin
        wa_lane <= wa_lane + 2'h1;
      end else begin
        wa_lane <= 2'h0;
        wa_word <= wa_word + 9'h001;
      end
    end else if (sweep_end) begin
      a_complete <= 1'b1;
    end
  end

  // acquisition buffer, converter writes only here
  always_ff @(posedge core_clk_i) begin
    if (store_en) begin
      if (cap_only) begin
        buf_a[wa_word][16 * wa_lane +: 16] <= rdg_i.cap;
      end else begin
        buf_a[wa_word] <= rdg_i;
      end
    end
  end

  // secondary buffer loaded by transfer only
  always_ff @(posedge core_clk_i) begin
    if (xfer_busy) begin
      buf_b[xfer_idx] <= buf_a[xfer_idx];
    end
  end

  // browse pointer; saturates at the buffer's capacity
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buffer_display_o <= 1'b0;
      bsel <= 1'b0;
      bptr <= 11'h001;
      bword <= 9'h000;
      blane <= 2'h0;
      show_location_index <= 1'b0;
    end else begin
      if (cmd[CMD_INDEX]) begin
        show_location_index <= !show_location_index;
      end
      if (cmd[CMD_ENTER]) begin
        // select buffer and show location 1
        buffer_display_o <= 1'b1;
        bsel <= cmd[CMD_SEL];
        bptr <= 11'h001;
        bword <= 9'h000;
        blane <= 2'h0;
      end else if (cmd[CMD_QUIT]) begin
        buffer_display_o <= 1'b0;
      end else if (buffer_display_o) begin
        if (cmd[CMD_UP] && bptr < (sel_co ? CAP_FAST : CAP_FULL)) begin
          bptr <= bptr + 11'h001;
          if (sel_co && blane != 2'h2) begin
            blane <= blane + 2'h1;
          end else begin
            blane <= 2'h0;
            bword <= bword + 9'h001;
          end
        end else if (cmd[CMD_DOWN] && bptr > 11'h001) begin
          bptr <= bptr - 11'h001;
          if (blane != 2'h0) begin
            blane <= blane - 2'h1;
          end else begin
            blane <= sel_co ? 2'h2 : 2'h0;
            bword <= bword - 9'h001;
          end
        end else if (cmd[CMD_FIRST]) begin
          bptr <= 11'h001;
          bword <= 9'h000;
          blane <= 2'h0;
        end else if (cmd[CMD_LAST] && sel_count != 11'h000) begin
          bptr <= sel_count;
          bword <= sel_last[10:2];
          blane <= sel_last[1:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_rdg <= 48'h000000000000;
    end else if (rdg_valid_i) begin
      // live readings land here regardless of storage
      last_rdg <= rdg_i;
    end
  end

  // display source; array read is async, output is registered
  assign view_word = bsel ? buf_b[bword] : buf_a[bword];
  assign view_co = sel_co;
  // empty buffer, or acquisition buffer incomplete at a fast rate, reads invalid
  assign view_invalid = (sel_count == 11'h000) ||
                        (!bsel && fast && !a_complete);
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      disp_o <= 48'h000000000000;
      disp_invalid_o <= 1'b0;
    end else if (!buffer_display_o) begin
      disp_o <= last_rdg;
      disp_invalid_o <= 1'b0;
    end else if (view_invalid) begin
      disp_o <= {INVALID_WORD, INVALID_WORD, INVALID_WORD};
      disp_invalid_o <= 1'b1;
    end else begin
      disp_invalid_o <= 1'b0;
      disp_o <= view_co ? {view_word[16 * blane +: 16], 32'h00000000}
                        : view_word;
      if (show_location_index) begin
        disp_o.bias <= {5'h00, bptr};
      end
    end
  end

endmodule : sweep_reading_buffer_ctrl

// *** testbench.sv ***
`timescale 1ns/10ps
// self-checking bench for the sweep reading buffer controller
module testbench;
  import sweep_buf_pkg::*;
  logic clk, rst_n, psel, pen, pwr, trig, go, rv, pready, perr, act, bdisp;
  logic inval;
  logic [7:0] addr;
  logic [31:0] wdata, prdata;
  logic [15:0] bias;
  logic [2:0] dly;
  reading_type val, rdg, disp;
  reading_type r [3];
  logic [31:0] exp_q [$], msk_q [$];
  int fails, comparisons;
  sweep_reading_buffer_ctrl #(.TICK_CYCLES(2)) dut (.core_clk_i(clk),
    .resetn_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(addr), .pwdata_i(wdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .trigger_i(trig), .rdg_valid_i(rv), .rdg_i(rdg),
    .bias_o(bias), .sweep_active_o(act), .buffer_display_o(bdisp),
    .disp_o(disp), .disp_invalid_o(inval));
  conv_model conv (.clk_i(clk), .rst_ni(rst_n), .go_i(go), .dly_i(dly),
    .val_i(val), .valid_o(rv), .rdg_o(rdg));
  task automatic report_and_stop;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, e);
    comparisons++;
    if (got !== e) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, e);
    end
  endtask : chk
  // request is held until ready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, addr, wdata} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, pen} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic cmd(input int b);
    apb(1'b1, A_CMD, 32'h1 << b);
  endtask : cmd
  task automatic fire;
    trig <= 1'b1;
    repeat (4) @(posedge clk);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : fire
  // converter answers after a random delay, fast or slow
  task automatic meas(input int i);
    repeat (8) @(posedge clk);
    r[i] = {$urandom(), 16'($urandom())};
    val <= r[i];
    dly <= 3'($urandom());
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : meas
  // read answers are matched against the oldest note
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr && exp_q.size() > 0)
      chk(prdata & msk_q.pop_front(), exp_q.pop_front());
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  initial begin
    {rst_n, psel, pen, pwr, trig, go, addr, wdata, dly, val} = '0;
    void'($urandom(32'h21340DB7));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CTRL, 32'h0, 32'hFF);
    rd(A_COUNT, 32'h1, 32'h7FF);
    rd(8'h40, 32'h0, '1);
    apb(1'b1, A_BIAS_SD, 32'h01230000);
    apb(1'b1, A_COUNT, 32'h3);
    for (int i = 0; i < 3; i++) begin
      fire();
      meas(i);
      rd(A_STATUS, i + 1, 32'h7FF);
      rd(A_LAST_CG, r[i][47:16], '1);
    end
    rd(A_STATUS, 32'h02000003, 32'h024007FF);
    chk(32'(bias), 32'h0123);
    cmd(CMD_ENTER);
    @(negedge clk);
    chk(32'(bdisp), 32'h1);
    rd(A_VIEW_CG, r[0][47:16], '1);
    cmd(CMD_UP);
    rd(A_VIEW_CG, r[1][47:16], '1);
    cmd(CMD_LAST);
    rd(A_VIEW_CG, r[2][47:16], '1);
    repeat (3) cmd(CMD_DOWN);
    rd(A_VIEW_CG, r[0][47:16], '1);
    cmd(CMD_LAST);
    cmd(CMD_FIRST);
    rd(A_VIEW_CG, r[0][47:16], '1);
    cmd(CMD_QUIT);
    @(negedge clk);
    chk(32'(bdisp), 32'h0);
    cmd(CMD_XFER);
    repeat (10) @(posedge clk);
    rd(A_STATUS, 32'h1800, 32'h3FFFFF);
    apb(1'b1, A_CMD, 32'h60);
    rd(A_VIEW_CG, r[0][47:16], '1);
    cmd(CMD_QUIT);
    cmd(CMD_ENTER);
    rd(A_VIEW_V, 32'h10000, 32'h10000);
    cmd(CMD_QUIT);
    cmd(CMD_XFER);
    repeat (4) @(posedge clk);
    rd(A_STATUS, 32'h0, 32'h3FFFFF);
    apb(1'b1, A_COUNT, 32'h2);
    apb(1'b1, A_CTRL, 32'h1);
    fire();
    for (int i = 0; i < 3; i++) meas(i);
    rd(A_STATUS, 32'h2, 32'h7FF);
    rd(A_LAST_CG, r[2][47:16], '1);
    fire();
    rd(A_STATUS, 32'h400000, 32'h4007FF);
    meas(0);
    apb(1'b1, A_CTRL, 32'h1);
    rd(A_STATUS, 32'h0, 32'h4007FF);
    apb(1'b1, A_CTRL, 32'h6);
    fire();
    meas(0);
    cmd(CMD_ENTER);
    rd(A_VIEW_V, 32'h10000, 32'h10000);
    cmd(CMD_QUIT);
    fire();
    meas(1);
    cmd(CMD_ENTER);
    rd(A_VIEW_V, 32'h0, 32'h10000);
    cmd(CMD_QUIT);
    fire();
    meas(2);
    rd(A_STATUS, 32'h1, 32'h20007FF);
    report_and_stop();
  end
endmodule : testbench
bind sweep_reading_buffer_ctrl sweep_buf_sva chk_i (.core_clk_i, .resetn_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
  .pslverr_o, .sweep_active_o, .buffer_display_o, .disp_o, .disp_invalid_o);
